// *** design/asp_host.sv ***
// Host controller for a 32K x 8 asynchronous static memory.
// Assumes DQ is returned synchronous to MCLK_I; the bench resolves the
// shared data wire from SRAM_DQ_OE_O.
//
// Functional notes
// - Write starts when both strobes low, ends on first strobe rising.
// - Data setup and hold are timed to the strobe that ends write.
// - Write data stable 30 ns before write end, may drop after end.
// - Address valid at least 60 ns before end of write.
// - Address valid at write start and unchanged until write end.
// - Strobe-ended write with output enable low lasts 25 plus 30 ns.
// - Controller never drives data while memory drives it.
// - Write strobe stays high through every read.
// - Read address valid before or as select falls.
`timescale 1ns/1ps
module asp_host (
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    // User request
    input  wire logic        REQ_I,
    input  wire logic        WRITE_I,
    input  wire logic [14:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    // User answer
    output logic             READY_O,
    output logic             DONE_O,
    output logic [7:0]       RDATA_O,
    // Memory strobes and address
    output logic             SRAM_CE_N_O,
    output logic             SRAM_WE_N_O,
    output logic             SRAM_OE_N_O,
    output logic [14:0]      SRAM_ADDR_O,
    // Memory data pins
    input  wire logic [7:0]  SRAM_DQ_I,
    output logic [7:0]       SRAM_DQ_O,
    output logic             SRAM_DQ_OE_O
);
    asp_pkg::asp_host_t host_q;
    asp_pkg::asp_host_t host_d;
    asp_tmr_if          tmr ();

    asp_timer u_timer (
        .mclk_i (MCLK_I),
        .rst_i  (RST_I),
        .t      (tmr.tmr)
    );

    always_comb begin
        host_d       = host_q;
        host_d.done  = 1'b0;
        tmr.load     = 1'b0;
        tmr.load_val = 4'h0;
        case (host_q.st)
            asp_pkg::ST_IDLE: begin
                if (REQ_I && host_q.ready) begin
                    host_d.ready = 1'b0;
                    host_d.addr  = ADDR_I;
                    host_d.ce_n  = 1'b0;
                    if (WRITE_I) begin
                        // Address and data settle before the strobe falls
                        host_d.st    = asp_pkg::ST_WSETUP;
                        host_d.dq_o  = WDATA_I;
                        host_d.dq_oe = 1'b1;
                        host_d.oe_n  = 1'b1;
                    end else begin
                        // Address and select change on the same edge
                        host_d.st   = asp_pkg::ST_RACCESS;
                        host_d.oe_n = 1'b0;
                        host_d.we_n = 1'b1;
                        tmr.load     = 1'b1;
                        tmr.load_val = asp_pkg::RD_ACCESS_CYC;
                    end
                end
            end
            asp_pkg::ST_WSETUP: begin
                host_d.st    = asp_pkg::ST_WPULSE;
                host_d.we_n  = 1'b0;
                tmr.load     = 1'b1;
                tmr.load_val = asp_pkg::WR_PULSE_CYC;
            end
            asp_pkg::ST_WPULSE: begin
                if (tmr.done) begin
                    // Both strobes rise together so the memory stays off
                    host_d.st   = asp_pkg::ST_WEND;
                    host_d.we_n = 1'b1;
                    host_d.ce_n = 1'b1;
                end
            end
            asp_pkg::ST_WEND: begin
                // Data and address held one cycle past the write end
                host_d.st    = asp_pkg::ST_IDLE;
                host_d.dq_oe = 1'b0;
                host_d.ready = 1'b1;
                host_d.done  = 1'b1;
            end
            asp_pkg::ST_RACCESS: begin
                if (tmr.done) begin
                    host_d.st    = asp_pkg::ST_RTURN;
                    host_d.rdata = SRAM_DQ_I;
                    host_d.done  = 1'b1;
                    host_d.ce_n  = 1'b1;
                    host_d.oe_n  = 1'b1;
                    tmr.load     = 1'b1;
                    tmr.load_val = asp_pkg::TURN_CYC;
                end
            end
            asp_pkg::ST_RTURN: begin
                // Memory may still drive DQ until its outputs turn off
                if (tmr.done) begin
                    host_d.st    = asp_pkg::ST_IDLE;
                    host_d.ready = 1'b1;
                end
            end
            default: begin
                host_d       = '0;
                host_d.st    = asp_pkg::ST_IDLE;
                host_d.ce_n  = 1'b1;
                host_d.we_n  = 1'b1;
                host_d.oe_n  = 1'b1;
                host_d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            host_q       <= '0;
            host_q.st    <= asp_pkg::ST_IDLE;
            host_q.ce_n  <= 1'b1;
            host_q.we_n  <= 1'b1;
            host_q.oe_n  <= 1'b1;
            host_q.ready <= 1'b1;
        end else begin
            host_q <= host_d;
        end
    end

    assign READY_O      = host_q.ready;
    assign DONE_O       = host_q.done;
    assign RDATA_O      = host_q.rdata;
    assign SRAM_CE_N_O  = host_q.ce_n;
    assign SRAM_WE_N_O  = host_q.we_n;
    assign SRAM_OE_N_O  = host_q.oe_n;
    assign SRAM_ADDR_O  = host_q.addr;
    assign SRAM_DQ_O    = host_q.dq_o;
    assign SRAM_DQ_OE_O = host_q.dq_oe;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    sequence s_wr_pulse;
        (!SRAM_WE_N_O && !SRAM_CE_N_O && SRAM_DQ_OE_O
         && $stable(SRAM_DQ_O) && $stable(SRAM_ADDR_O)) [*6];
    endsequence

    sequence s_wr_close;
        SRAM_WE_N_O && SRAM_CE_N_O && SRAM_DQ_OE_O;
    endsequence

    property p_wr_window;
        $fell(SRAM_WE_N_O) |-> s_wr_pulse ##1 s_wr_close;
    endproperty
    a_wr_window: assert property (p_wr_window)
        else $error("write window not six cycles with stable data");

    property p_wr_end_together;
        $rose(SRAM_WE_N_O) |-> $rose(SRAM_CE_N_O) && !$past(SRAM_CE_N_O);
    endproperty
    a_wr_end_together: assert property (p_wr_end_together)
        else $error("write strobe and select did not end together");

    property p_wr_hold;
        $rose(SRAM_WE_N_O) |-> SRAM_DQ_OE_O && $stable(SRAM_DQ_O)
            && $stable(SRAM_ADDR_O) ##1 !SRAM_DQ_OE_O;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write data or address not held after write end");

    property p_wr_start;
        $fell(SRAM_WE_N_O) |-> $past(!SRAM_CE_N_O) && $past(SRAM_DQ_OE_O)
            && $stable(SRAM_ADDR_O);
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("address or data not set before write start");

    property p_addr_stable_sel;
        (!SRAM_CE_N_O && $past(!SRAM_CE_N_O)) |-> $stable(SRAM_ADDR_O);
    endproperty
    a_addr_stable_sel: assert property (p_addr_stable_sel)
        else $error("address changed while selected");

    property p_no_contention;
        !SRAM_OE_N_O |-> !SRAM_DQ_OE_O && SRAM_WE_N_O;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("data driven or write strobe low during read");

    property p_turnaround;
        $rose(SRAM_OE_N_O) |-> (!SRAM_DQ_OE_O && !READY_O) [*3];
    endproperty
    a_turnaround: assert property (p_turnaround)
        else $error("bus turnaround shorter than three cycles");

    property p_wr_oe_high;
        !SRAM_WE_N_O |-> SRAM_OE_N_O;
    endproperty
    a_wr_oe_high: assert property (p_wr_oe_high)
        else $error("output enable low during write");

    sequence s_rd_access;
        (!SRAM_OE_N_O && !SRAM_CE_N_O && !DONE_O) [*7];
    endsequence

    property p_read_access;
        $fell(SRAM_OE_N_O) |-> s_rd_access ##1 (DONE_O && SRAM_OE_N_O);
    endproperty
    a_read_access: assert property (p_read_access)
        else $error("read access not seven cycles");
endmodule : asp_host

// *** design/asp_pkg.sv ***
// Constants and types for the asynchronous SRAM port controller.
// Assumes a single 100 MHz clock; all timing counts derive from it.
package asp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 15;
    localparam int DATA_W        = 8;

    // Pin timing of the memory, in ns
    localparam int T_ADDR_SETUP_TO_WRITE_END_NS     = 60;
    localparam int T_WRITE_DATA_SETUP_NS            = 30;
    localparam int T_WRITE_STROBE_OUTPUT_OFF_NS     = 25;
    localparam int T_ADDRESS_ACCESS_DELAY_NS        = 70;
    localparam int T_OUTPUT_ENABLE_ACCESS_DELAY_NS  = 35;
    localparam int T_OUTPUT_OFF_NS                  = 25;

    // Least times, rounded up to whole cycles
    localparam int WR_PULSE_NS =
        (T_ADDR_SETUP_TO_WRITE_END_NS >
         T_WRITE_STROBE_OUTPUT_OFF_NS + T_WRITE_DATA_SETUP_NS) ?
        T_ADDR_SETUP_TO_WRITE_END_NS :
        T_WRITE_STROBE_OUTPUT_OFF_NS + T_WRITE_DATA_SETUP_NS;
    localparam logic [3:0] WR_PULSE_CYC =
        4'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RD_ACCESS_CYC =
        4'((T_ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] TURN_CYC =
        4'((T_OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_WSETUP  = 6'h02,
        ST_WPULSE  = 6'h04,
        ST_WEND    = 6'h08,
        ST_RACCESS = 6'h10,
        ST_RTURN   = 6'h20
    } asp_state_t;

    typedef struct packed {
        asp_state_t          st;
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_o;
        logic                dq_oe;
        logic [DATA_W-1:0]   rdata;
        logic                ready;
        logic                done;
    } asp_host_t;

    typedef struct packed {
        logic [3:0] cnt;
    } asp_timer_t;
endpackage : asp_pkg

// *** design/asp_timer.sv ***
// Down counter timing the write pulse, read access and turnaround phases of a memory cycle.
// Assumes load values of at least one.
`timescale 1ns/1ps
module asp_timer (
    // Clock and reset
    input  wire logic  mclk_i,
    input  wire logic  rst_i,
    // Sequencer side
    asp_tmr_if.tmr     t
);
    asp_pkg::asp_timer_t tmr_q;
    asp_pkg::asp_timer_t tmr_d;

    always_comb begin
        tmr_d = tmr_q;
        if (t.load) begin
            tmr_d.cnt = t.load_val;
        end else if (tmr_q.cnt != 4'h0) begin
            tmr_d.cnt = tmr_q.cnt - 4'h1;
        end
    end

    // Last cycle of the loaded span
    assign t.done = (tmr_q.cnt == 4'h1);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end
endmodule : asp_timer

// *** design/asp_tmr_if.sv ***
// Link between the port sequencer and its cycle timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface asp_tmr_if;
    logic       load;
    logic [3:0] load_val;
    logic       done;
    modport ctl (output load, output load_val, input done);
    modport tmr (input load, input load_val, output done);
endinterface : asp_tmr_if

// *** sim/asp_host_tb.sv ***
// Self-checking bench for the asynchronous SRAM host controller.
// Assumes asp_sram_model stands on the memory pins.
`timescale 1ns/1ps
module asp_host_tb;
    logic        mclk, rst, req, wr, ready, done, ce_n, we_n, oe_n;
    logic        dq_oe, mem_oe;
    logic [14:0] addr, sram_addr;
    logic [7:0]  wdata, rdata, sram_dq, mem_dq, dq_w;
    int          num_errors, total_checks;

    assign dq_w = dq_oe ? sram_dq : mem_dq;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    asp_host u_asp_host (.MCLK_I(mclk), .RST_I(rst), .REQ_I(req),
        .WRITE_I(wr), .ADDR_I(addr), .WDATA_I(wdata), .READY_O(ready),
        .DONE_O(done), .RDATA_O(rdata), .SRAM_CE_N_O(ce_n),
        .SRAM_WE_N_O(we_n), .SRAM_OE_N_O(oe_n), .SRAM_ADDR_O(sram_addr),
        .SRAM_DQ_I(dq_w), .SRAM_DQ_O(sram_dq), .SRAM_DQ_OE_O(dq_oe));
    asp_sram_model u_asp_sram_model (.ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .addr_i(sram_addr), .dq_i(dq_w), .dq_o(mem_dq),
        .dq_oe_o(mem_oe));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // Contention is watched all run, not only inside accesses
    always @(negedge mclk) begin
        if (!rst && mem_oe === 1'b1) chk(16'(dq_oe), 16'h0000);
    end

    // Called at a falling edge; strobes judged on every cycle
    task automatic access(input logic w, input logic [14:0] a,
                          input logic [7:0] d);
        int k;
        int we_lo;
        logic [15:0] pins;
        k = 0;
        we_lo = 0;
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        while (ready !== 1'b1 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        k = 0;
        @(negedge mclk);
        req = 1'b0;
        chk({ce_n, sram_addr}, {1'b0, a});
        while (done !== 1'b1 && k < 20) begin
            pins = 16'({ce_n, we_n, dq_oe, sram_dq});
            if (we_n === 1'b0) we_lo++;
            if (w) chk(16'(oe_n), 16'h0001);
            else chk(16'(we_n), 16'h0001);
            if (w && k == 6) chk(pins, 16'({3'b001, d}));
            if (w && k == 7) chk(pins, 16'({3'b111, d}));
            @(negedge mclk);
            k++;
        end
        chk(16'(k), w ? 16'h0008 : 16'h0007);
        chk(16'(we_lo), w ? 16'h0006 : 16'h0000);
        if (!w) chk(16'(rdata), 16'(d));
    endtask : access

    task automatic reset_values();
        chk(16'({ready, done, ce_n, we_n, oe_n, dq_oe}), 16'h002e);
        chk({1'b0, sram_addr}, 16'h0000);
        chk(16'(rdata), 16'h0000);
    endtask : reset_values

    initial begin
        rst = 1'b1;
        req = 1'b0;
        wr = 1'b0;
        addr = 15'h0000;
        wdata = 8'h00;
        num_errors = 0;
        total_checks = 0;
        repeat (16) @(negedge mclk);
        reset_values();
        rst = 1'b0;
        @(negedge mclk);
        reset_values();
        // Back-to-back writes at both address ends, then read back
        access(1'b1, 15'h0000, 8'ha5);
        access(1'b1, 15'h7fff, 8'h5a);
        access(1'b0, 15'h0000, 8'ha5);
        access(1'b0, 15'h7fff, 8'h5a);
        // Overwrite must not disturb the neighbour at the other end
        access(1'b1, 15'h7fff, 8'h3c);
        access(1'b0, 15'h7fff, 8'h3c);
        access(1'b0, 15'h0000, 8'ha5);
        // Deselected long enough for the memory to drop to standby
        repeat (8) @(negedge mclk);
        chk(16'(u_asp_sram_model.standby), 16'h0001);
        report_and_stop();
    end

    // Whole run needs about a hundred cycles; this is about a hundred times that
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule : asp_host_tb

// *** sim/asp_sram_model.sv ***
// Behavioural 32K x 8 asynchronous static memory.
// Assumes a host that drives strobes and address from flops.
`timescale 1ns/1ps
module asp_sram_model #(
    parameter int T_ACC_NS  = 70,
    parameter int T_OE_NS   = 35,
    parameter int T_HOLD_NS = 10
) (
    // Strobes and address
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [14:0] addr_i,
    // Data pins
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe_o
);
    logic [7:0] mem [0:32767];
    logic       wr_win;
    logic       standby;
    logic [7:0] last_q;
    realtime    t_addr;
    realtime    t_ce;
    realtime    t_oe;

    assign wr_win = !ce_n_i && !we_n_i;
    // Data taken at the strobe edge that closes the overlap
    always @(negedge wr_win) mem[addr_i] = dq_i;
    always @(addr_i) t_addr = $realtime;
    always @(negedge ce_n_i) t_ce = $realtime;
    always @(negedge oe_n_i) t_oe = $realtime;
    always @(ce_n_i) standby <= #70 ce_n_i;

    // Steps at half-ns points so the host never races the answer
    initial begin
        last_q = 8'h00;
        dq_o = 8'hff;
        dq_oe_o = 1'b0;
        #0.5;
        forever begin
            dq_oe_o = !ce_n_i && we_n_i && !oe_n_i;
            if (dq_oe_o && $realtime - t_addr >= T_ACC_NS - 1
                && $realtime - t_ce >= T_ACC_NS - 1
                && $realtime - t_oe >= T_OE_NS - 1) begin
                dq_o = mem[addr_i];
                last_q = dq_o;
            end else if (dq_oe_o && $realtime - t_addr < T_HOLD_NS) begin
                dq_o = last_q;
            end else begin
                dq_o = ~dq_o;
            end
            #1;
        end
    end
endmodule : asp_sram_model
